/* cms_seq_map.vh */
/*
 * Constants of the machine-cycle sequencer: instruction classes, machine
 * cycle kinds, state counts per cycle kind, state windows of the bus
 * strobes, and fixed addresses and reset values.
 * Assumes it is included by its bare name from the sequencer source.
 */
`ifndef CMS_SEQ_MAP_VH
`define CMS_SEQ_MAP_VH

// Instruction classes
`define CMS_C_LD_REG      4'h0
`define CMS_C_LD_IMM      4'h1
`define CMS_C_LD_IDX      4'h2
`define CMS_C_LD_PAIR     4'h3
`define CMS_C_PUSH        4'h4
`define CMS_C_COPY        4'h5
`define CMS_C_COPY_REP    4'h6
`define CMS_C_NMI         4'h7
`define CMS_C_INT0_RST    4'h8
`define CMS_C_INT0_CALL   4'h9
`define CMS_C_INT2        4'ha

// Machine cycle kinds
`define CMS_M_NONE        4'h0
`define CMS_M_OPCODE      4'h1
`define CMS_M_OPERAND     4'h2
`define CMS_M_OPER_LOW    4'h3
`define CMS_M_OPER_HIGH   4'h4
`define CMS_M_MEM_READ    4'h5
`define CMS_M_MEM_WRITE   4'h6
`define CMS_M_READ_LOW    4'h7
`define CMS_M_READ_HIGH   4'h8
`define CMS_M_STACK_HIGH  4'h9
`define CMS_M_STACK_LOW   4'ha
`define CMS_M_INTERNAL    4'hb
`define CMS_M_INT_ACK     4'hc

// Minimum clock states per cycle kind
`define CMS_LEN_FETCH     3'h4
`define CMS_LEN_FETCH_EXT 3'h5
`define CMS_LEN_MEM       3'h3
`define CMS_LEN_LONG      3'h5
`define CMS_LEN_ACK       3'h6

// State windows
`define CMS_T_FIRST       3'h1
`define CMS_T_WAIT        3'h2
`define CMS_T_REFRESH     3'h3
`define CMS_T_ACK_REFRESH 3'h5
`define CMS_T_EXTRA       3'h4

// Addresses and reset values
`define CMS_NMI_ADDR      16'h0066
`define CMS_PC_STEP       16'h0001
`define CMS_PC_REWIND     16'h0002
`define CMS_PC_RESET      16'h0000
`define CMS_SP_RESET      16'hffff

`endif

/* cms_sequencer.v */
/*
 * Machine-cycle and clock-state sequencer of an 8-bit processor core.
 * Runs the bus cycles of each instruction class, one state per clock,
 * holds program counter and stack pointer, and forms cycle addresses.
 * Assumes decode logic on clk starts it with a class code, and that the
 * wait and data bus pins arrive asynchronously and are resynchronised.
 */
// Behaviour
// - Register-to-register load is one four-state opcode fetch.
// - Immediate load is four-state fetch then three-state operand read.
// - Indexed load: two fetches, displacement read, five-state address cycle, access.
// - Pair load: two fetches, then address operands low byte first.
// - Pair load reads low register data first, then high register data.
// - Push lengthens first cycle by one state, decrementing stack pointer there.
// - Push writes high byte, decrements again, writes low byte; pointer stays there.
// - Single copy: two fetches, read, five-state write stepping the counter; 16 states.
// - Repeating copy, unless last, adds five-state cycle moving program counter back two.
// - Non-final repeat takes 21 states; refetch refreshes and samples requests.
// - Non-maskable response takes 11 states, first a five-state dummy fetch.
// - Non-maskable: counter held, bus byte ignored, restart at 66H.
// - Non-maskable: two cycles after dummy fetch stack the program counter.
// - Mode 0 restart: stack program counter, continue at restart address.
// - Mode 0 call: two target reads low first, then two stack writes.
// - Mode 2: device vector in acknowledge; stack counter in cycles two, three.
// - Mode 2: vector-base and vector point to table read in cycles four, five.
`include "cms_seq_map.vh"
`default_nettype none
module cms_sequencer (
  input  wire        clk,
  input  wire        reset,
  input  wire        start,
  input  wire [3:0]  instr_class,
  input  wire        copy_last,
  input  wire        mode0_call,
  input  wire [15:0] index_register,
  input  wire [15:0] copy_src,
  input  wire [15:0] copy_dst,
  input  wire [15:0] push_pair,
  input  wire [15:0] restart_target,
  input  wire [7:0]  vector_base,
  input  wire        wait_n,
  input  wire [7:0]  data_pin,
  output reg         busy,
  output reg         done,
  output reg  [3:0]  cycle_type,
  output reg  [2:0]  machine_step,
  output reg  [2:0]  tstate,
  output reg  [15:0] address,
  output reg  [15:0] pc,
  output reg  [15:0] stack_pointer,
  output reg  [7:0]  write_data,
  output reg  [15:0] read_word,
  output reg         fetch_cycle_indicator,
  output reg         io_request_strobe,
  output reg         refresh,
  output reg         sample_requests,
  output reg         length_count_step
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        wait_meta;
  reg        wait_sync_n;
  reg [7:0]  data_meta;
  reg [7:0]  data_sync;
  reg [3:0]  cls;
  reg [15:0] work_addr;

  reg        next_busy;
  reg        next_done;
  reg [3:0]  next_cls;
  reg [3:0]  next_type;
  reg [2:0]  next_step;
  reg [2:0]  next_tstate;
  reg [15:0] next_address;
  reg [15:0] next_pc;
  reg [15:0] next_sp;
  reg [15:0] next_work;
  reg [7:0]  next_wdata;
  reg [15:0] next_rword;
  reg        next_sample;
  reg        next_count_step;
  reg        enter;
  reg [7:0]  cur_info;
  reg [7:0]  new_info;
  reg        stall;

  function [7:0] ent;
    input [3:0] kind;
    input [2:0] len;
    begin
      ent = {1'b1, kind, len};
    end
  endfunction

  // Cycle table per class: {valid, kind, minimum states}
  function [7:0] step_info;
    input [3:0] c;
    input [2:0] s;
    input       last;
    reg   [7:0] f4;
    begin
      f4 = ent(`CMS_M_OPCODE, `CMS_LEN_FETCH);
      step_info = 8'h00;
      case (c)
        `CMS_C_LD_REG: if (s == 3'h0) step_info = f4;
        `CMS_C_LD_IMM: case (s)
          3'h0:    step_info = f4;
          3'h1:    step_info = ent(`CMS_M_OPERAND, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        `CMS_C_LD_IDX: case (s)
          3'h0, 3'h1: step_info = f4;
          3'h2:    step_info = ent(`CMS_M_OPERAND, `CMS_LEN_MEM);
          3'h3:    step_info = ent(`CMS_M_INTERNAL, `CMS_LEN_LONG);
          3'h4:    step_info = ent(`CMS_M_MEM_READ, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        `CMS_C_LD_PAIR: case (s)
          3'h0, 3'h1: step_info = f4;
          3'h2:    step_info = ent(`CMS_M_OPER_LOW, `CMS_LEN_MEM);
          3'h3:    step_info = ent(`CMS_M_OPER_HIGH, `CMS_LEN_MEM);
          3'h4:    step_info = ent(`CMS_M_READ_LOW, `CMS_LEN_MEM);
          3'h5:    step_info = ent(`CMS_M_READ_HIGH, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        `CMS_C_PUSH, `CMS_C_NMI: case (s)
          3'h0:    step_info = ent(`CMS_M_OPCODE, `CMS_LEN_FETCH_EXT);
          3'h1:    step_info = ent(`CMS_M_STACK_HIGH, `CMS_LEN_MEM);
          3'h2:    step_info = ent(`CMS_M_STACK_LOW, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        `CMS_C_COPY, `CMS_C_COPY_REP: case (s)
          3'h0, 3'h1: step_info = f4;
          3'h2:    step_info = ent(`CMS_M_MEM_READ, `CMS_LEN_MEM);
          3'h3:    step_info = ent(`CMS_M_MEM_WRITE, `CMS_LEN_LONG);
          3'h4:    if (c == `CMS_C_COPY_REP && !last)
                     step_info = ent(`CMS_M_INTERNAL, `CMS_LEN_LONG);
          default: step_info = 8'h00;
        endcase
        `CMS_C_INT0_RST, `CMS_C_INT2: case (s)
          3'h0:    step_info = ent(`CMS_M_INT_ACK, `CMS_LEN_ACK);
          3'h1:    step_info = ent(`CMS_M_STACK_HIGH, `CMS_LEN_MEM);
          3'h2:    step_info = ent(`CMS_M_STACK_LOW, `CMS_LEN_MEM);
          3'h3:    if (c == `CMS_C_INT2) step_info = ent(`CMS_M_READ_LOW, `CMS_LEN_MEM);
          3'h4:    if (c == `CMS_C_INT2) step_info = ent(`CMS_M_READ_HIGH, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        `CMS_C_INT0_CALL: case (s)
          3'h0:    step_info = ent(`CMS_M_INT_ACK, `CMS_LEN_ACK);
          3'h1:    step_info = ent(`CMS_M_READ_LOW, `CMS_LEN_MEM);
          3'h2:    step_info = ent(`CMS_M_READ_HIGH, `CMS_LEN_MEM);
          3'h3:    step_info = ent(`CMS_M_STACK_HIGH, `CMS_LEN_MEM);
          3'h4:    step_info = ent(`CMS_M_STACK_LOW, `CMS_LEN_MEM);
          default: step_info = 8'h00;
        endcase
        default: step_info = 8'h00;
      endcase
    end
  endfunction

  always @* begin
    next_busy       = busy;
    next_done       = 1'b0;
    next_cls        = cls;
    next_type       = cycle_type;
    next_step       = machine_step;
    next_tstate     = tstate;
    next_address    = address;
    next_pc         = pc;
    next_sp         = stack_pointer;
    next_work       = work_addr;
    next_wdata      = write_data;
    next_rword      = read_word;
    next_sample     = 1'b0;
    next_count_step = 1'b0;
    enter           = 1'b0;
    new_info        = 8'h00;
    cur_info        = step_info(cls, machine_step, copy_last);
    // Internal cycles never touch the bus, so waits do not stretch them
    stall = (tstate == `CMS_T_WAIT) && !wait_sync_n &&
            (cycle_type != `CMS_M_INTERNAL);
    if (!busy) begin
      if (start) begin
        next_cls  = instr_class;
        next_step = 3'h0;
        next_busy = ST_RUN;
        enter     = 1'b1;
      end
    end else if (!stall && tstate != cur_info[2:0]) begin
      next_tstate = tstate + 3'h1;
      if (cls == `CMS_C_PUSH && cycle_type == `CMS_M_OPCODE &&
          tstate == `CMS_T_EXTRA)
        next_sp = stack_pointer - `CMS_PC_STEP;
    end else if (!stall) begin
      case (cycle_type)
        `CMS_M_OPCODE: begin
          if (cls != `CMS_C_NMI)
            next_pc = pc + `CMS_PC_STEP;
          next_sample = 1'b1;
        end
        `CMS_M_INT_ACK: begin
          next_sample = 1'b1;
          next_work = (cls == `CMS_C_INT2) ? {vector_base, data_sync} : pc;
          if (cls == `CMS_C_INT0_RST && mode0_call)
            next_cls = `CMS_C_INT0_CALL;
        end
        `CMS_M_OPERAND, `CMS_M_OPER_LOW: begin
          next_rword[7:0] = data_sync;
          next_pc = pc + `CMS_PC_STEP;
        end
        `CMS_M_OPER_HIGH: begin
          next_rword[15:8] = data_sync;
          next_work = {data_sync, read_word[7:0]};
          next_pc = pc + `CMS_PC_STEP;
        end
        `CMS_M_MEM_READ, `CMS_M_READ_LOW: next_rword[7:0] = data_sync;
        `CMS_M_READ_HIGH: next_rword[15:8] = data_sync;
        `CMS_M_MEM_WRITE: next_count_step = 1'b1;
        `CMS_M_STACK_HIGH: next_sp = stack_pointer - `CMS_PC_STEP;
        `CMS_M_INTERNAL:
          if (cls == `CMS_C_COPY_REP)
            next_pc = pc - `CMS_PC_REWIND;
        default: next_pc = pc;
      endcase
      new_info = step_info(next_cls, machine_step + 3'h1, copy_last);
      if (new_info[7]) begin
        next_step = machine_step + 3'h1;
        enter     = 1'b1;
      end else begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_type = `CMS_M_NONE;
        next_tstate = 3'h0;
        case (cls)
          `CMS_C_NMI:       next_pc = `CMS_NMI_ADDR;
          `CMS_C_INT0_RST:  next_pc = restart_target;
          `CMS_C_INT0_CALL,
          `CMS_C_INT2:      next_pc = next_rword;
          default:          next_pc = next_pc;
        endcase
      end
    end
    if (enter) begin
      new_info    = step_info(next_cls, next_step, copy_last);
      next_type   = new_info[6:3];
      next_tstate = `CMS_T_FIRST;
      case (next_type)
        `CMS_M_MEM_READ:
          next_address = (next_cls == `CMS_C_LD_IDX) ? next_work : copy_src;
        `CMS_M_MEM_WRITE: next_address = copy_dst;
        `CMS_M_READ_LOW:  next_address = next_work;
        `CMS_M_READ_HIGH: next_address = next_work + `CMS_PC_STEP;
        `CMS_M_STACK_HIGH: begin
          // Only push predecrements during its stretched fetch
          next_sp = (next_cls == `CMS_C_PUSH) ? next_sp : next_sp - `CMS_PC_STEP;
          next_address = next_sp;
          next_wdata = (next_cls == `CMS_C_PUSH) ? push_pair[15:8] : pc[15:8];
        end
        `CMS_M_STACK_LOW: begin
          next_address = next_sp;
          next_wdata = (next_cls == `CMS_C_PUSH) ? push_pair[7:0] : pc[7:0];
        end
        `CMS_M_INTERNAL: begin
          if (next_cls == `CMS_C_LD_IDX)
            next_work = index_register +
                        {{8{next_rword[7]}}, next_rword[7:0]};
          next_address = address;
        end
        default: next_address = next_pc;
      endcase
    end
  end

  // Fetch indicator and io strobe overlap in ack cycles for the device byte
  always @(posedge clk) begin
    if (reset) begin
      wait_meta             <= 1'b1;
      wait_sync_n           <= 1'b1;
      data_meta             <= 8'h00;
      data_sync             <= 8'h00;
      busy                  <= ST_IDLE;
      done                  <= 1'b0;
      cls                   <= `CMS_C_LD_REG;
      cycle_type            <= `CMS_M_NONE;
      machine_step          <= 3'h0;
      tstate                <= 3'h0;
      address               <= `CMS_PC_RESET;
      pc                    <= `CMS_PC_RESET;
      stack_pointer         <= `CMS_SP_RESET;
      work_addr             <= `CMS_PC_RESET;
      write_data            <= 8'h00;
      read_word             <= 16'h0000;
      fetch_cycle_indicator <= 1'b0;
      io_request_strobe     <= 1'b0;
      refresh               <= 1'b0;
      sample_requests       <= 1'b0;
      length_count_step     <= 1'b0;
    end else begin
      wait_meta             <= wait_n;
      wait_sync_n           <= wait_meta;
      data_meta             <= data_pin;
      data_sync             <= data_meta;
      busy                  <= next_busy;
      done                  <= next_done;
      cls                   <= next_cls;
      cycle_type            <= next_type;
      machine_step          <= next_step;
      tstate                <= next_tstate;
      address               <= next_address;
      pc                    <= next_pc;
      stack_pointer         <= next_sp;
      work_addr             <= next_work;
      write_data            <= next_wdata;
      read_word             <= next_rword;
      fetch_cycle_indicator <= (next_type == `CMS_M_OPCODE && next_tstate != 3'h0 &&
                                next_tstate < `CMS_T_REFRESH) ||
                               (next_type == `CMS_M_INT_ACK &&
                                next_tstate < `CMS_T_ACK_REFRESH);
      io_request_strobe     <= next_type == `CMS_M_INT_ACK &&
                               next_tstate >= `CMS_T_REFRESH &&
                               next_tstate < `CMS_T_ACK_REFRESH;
      refresh               <= (next_type == `CMS_M_OPCODE &&
                                next_tstate >= `CMS_T_REFRESH) ||
                               (next_type == `CMS_M_INT_ACK &&
                                next_tstate >= `CMS_T_ACK_REFRESH);
      sample_requests       <= next_sample;
      length_count_step     <= next_count_step;
    end
  end

endmodule // cms_sequencer
`default_nettype wire

/* cms_seq_sva.sv */
/* Checker of the machine-cycle sequencer, seeing only its ports.
   Assumes one clock and a synchronous active-high reset. */
`include "cms_seq_map.vh"
`default_nettype none
module cms_seq_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [3:0]  instr_class,
  input wire logic        copy_last,
  input wire logic        mode0_call,
  input wire logic        wait_n,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [3:0]  cycle_type,
  input wire logic [2:0]  tstate,
  input wire logic [15:0] pc,
  input wire logic [15:0] stack_pointer,
  input wire logic        fetch_cycle_indicator,
  input wire logic        io_request_strobe,
  input wire logic        refresh,
  input wire logic        sample_requests,
  input wire logic        length_count_step
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  cnt;
  logic [3:0]  cls;
  logic        waited;
  logic        call_seen;
  logic        last_seen;
  logic [15:0] sp0;
  logic [15:0] pc0;
  function automatic int exp_len(logic [3:0] c, logic last, logic call);
    case (c)
      4'h0: return 4;
      4'h1: return 7;
      4'h2: return 19;
      4'h3: return 20;
      4'h4: return 11;
      4'h5: return 16;
      4'h6: return last ? 16 : 21;
      4'h7: return 11;
      4'h8: return call ? 18 : 12;
      default: return 18;
    endcase
  endfunction
  // Totals are minimums, so any wait seen during the run disarms the count check
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 9'h000;
      waited <= 1'b1;
      call_seen <= 1'b0;
      last_seen <= 1'b1;
    end else if (start && !busy) begin
      cnt <= 9'h000;
      cls <= instr_class;
      waited <= !wait_n;
      sp0 <= stack_pointer;
      pc0 <= pc;
    end else if (busy) begin
      cnt <= cnt + 9'h001;
      waited <= waited | !wait_n;
      // Keep the levels as the sequencer read them; they may move once done rises
      if (cycle_type == `CMS_M_INT_ACK) call_seen <= mode0_call;
      if (cycle_type == `CMS_M_MEM_WRITE) last_seen <= copy_last;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_fetch_end;
    (cycle_type == `CMS_M_OPCODE || cycle_type == `CMS_M_INT_ACK) && tstate >= 3'h3
      ##1 tstate <= 3'h1;
  endsequence
  AST_TOTAL_STATES: assert property (
    done && !waited |-> cnt == exp_len(cls, last_seen, call_seen))
    else $error("state total wrong for class");
  AST_NMI_RESTART: assert property (
    done && cls == `CMS_C_NMI |-> pc == `CMS_NMI_ADDR) else $error("restart address wrong");
  AST_STACK_DEPTH: assert property (
    done && (cls == `CMS_C_PUSH || cls == `CMS_C_NMI) |-> stack_pointer == sp0 - 16'h0002)
    else $error("stack pointer not lowered by two");
  AST_COPY_PC: assert property (
    done && (cls == `CMS_C_COPY || cls == `CMS_C_COPY_REP) |-> pc == pc0
      + ((cls == `CMS_C_COPY_REP && !last_seen) ? 16'h0000 : 16'h0002))
    else $error("program counter wrong after copy");
  AST_FETCH_WINDOW: assert property (
    cycle_type == `CMS_M_OPCODE && tstate != 3'h0 |-> fetch_cycle_indicator == (tstate <= 3'h2)
      && refresh == (tstate >= 3'h3)) else $error("fetch strobes misplaced");
  AST_ACK_WINDOW: assert property (
    cycle_type == `CMS_M_INT_ACK |-> io_request_strobe == (tstate == 3'h3 || tstate == 3'h4)
      && fetch_cycle_indicator == (tstate <= 3'h4)) else $error("ack strobes misplaced");
  AST_SAMPLE_AFTER_FETCH: assert property (
    s_fetch_end |-> sample_requests) else $error("requests not sampled after fetch");
  AST_COPY_STEP: assert property (
    cycle_type == `CMS_M_MEM_WRITE && tstate == 3'h5 |=> length_count_step)
    else $error("length counter not stepped");
  AST_ADVANCE: assert property (
    busy && tstate != 3'h2 && tstate != 3'h0 ##1 busy
      |-> tstate == 3'h1 || tstate == $past(tstate) + 3'h1) else $error("state skipped");
  AST_START: assert property (
    start && !busy |=> busy && tstate == 3'h1 ##1 busy) else $error("start not taken");
  cover property (done && cls == `CMS_C_COPY_REP && !last_seen);
  cover property (cycle_type == `CMS_M_INT_ACK && io_request_strobe);
  cover property (busy && tstate == 3'h2 && !wait_n);
endmodule // cms_seq_sva
bind cms_sequencer cms_seq_sva chk (.*);
`default_nettype wire

/* cms_bus_model.sv */
/* Memory and interrupting peripheral beside the sequencer bus.
   Assumes it sees the sequencer outputs on the same clock. */
`include "cms_seq_map.vh"
`default_nettype none
module cms_bus_model (
  input  wire logic        clk,
  input  wire logic [3:0]  cycle_type,
  input  wire logic [2:0]  tstate,
  input  wire logic [15:0] address,
  input  wire logic        fetch_cycle_indicator,
  input  wire logic        io_request_strobe,
  input  wire logic        slow,
  input  wire logic [7:0]  ack_byte,
  output var  logic [7:0]  data_pin,
  output var  logic        wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  logic [1:0] hold = 2'h0;
  logic       rd;
  logic       ack;
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  assign rd = tstate != 3'h0 && cycle_type >= `CMS_M_OPCODE
    && cycle_type <= `CMS_M_READ_HIGH && cycle_type != `CMS_M_MEM_WRITE;
  assign ack = cycle_type == `CMS_M_INT_ACK && fetch_cycle_indicator
    && io_request_strobe;
  // A released bus shows the inverse of its last value, never a stale byte
  assign data_pin = ack ? ack_byte : rd ? mem(address) : ~last;
  assign wait_n = hold == 2'h0;
  always @(posedge clk) begin
    last <= data_pin;
    // Raised from fetch T3: the sequencer sees the pin two clocks late, at operand T2
    if (slow && tstate == 3'h3 && cycle_type == `CMS_M_OPCODE)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end
endmodule // cms_bus_model
`default_nettype wire

/* cms_testbench.sv */
/* Self-checking bench of the machine-cycle sequencer.
   Assumes the bound checker and the bus model stand beside the sequencer. */
`include "cms_seq_map.vh"
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, start = 1'b0, copy_last = 1'b1, mode0_call = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  instr_class = 4'h0;
  logic [15:0] index_register = 16'h2040, copy_src = 16'h3000, copy_dst = 16'h4000;
  logic [15:0] push_pair = 16'h1234, restart_target = 16'h0038;
  logic [7:0]  vector_base = 8'h51, ack_byte = 8'h7e;
  logic        busy, done, fetch_cycle_indicator, io_request_strobe, refresh;
  logic        sample_requests, length_count_step, wait_n;
  logic [3:0]  cycle_type;
  logic [2:0]  machine_step, tstate;
  logic [15:0] address, pc, stack_pointer, read_word, sp0, pc0, t;
  logic [7:0]  write_data, data_pin, d;
  logic [15:0] cap_a [16];
  logic [7:0]  cap_d [16];
  int          fails = 0, comparisons = 0, steps = 0, cyc = 0;
  cms_sequencer dut (.*);
  cms_bus_model bus (.*);
  always #10 clk = ~clk;
  // Captures on the falling edge, clear of the design's own updates
  always @(negedge clk) begin
    if (tstate == 3'h1) cap_a[cycle_type] = address;
    if (tstate == 3'h3) cap_d[cycle_type] = write_data;
    if (length_count_step === 1'b1) steps++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic go(input logic [3:0] c, output int n);
    sp0 = stack_pointer;
    pc0 = pc;
    instr_class = c;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic t_loads;
    int n;
    `CHK("pc_reset", `CMS_PC_RESET, pc);
    `CHK("sp_reset", `CMS_SP_RESET, stack_pointer);
    go(`CMS_C_LD_REG, n);
    `CHK("reg_states", 4, n);
    go(`CMS_C_LD_IMM, n);
    `CHK("imm_states", 7, n);
    `CHK("imm_addr", pc0 + 16'h0001, cap_a[`CMS_M_OPERAND]);
    go(`CMS_C_LD_IDX, n);
    d = bus.mem(cap_a[`CMS_M_OPERAND]);
    `CHK("idx_states", 19, n);
    `CHK("idx_addr", index_register + {{8{d[7]}}, d}, cap_a[`CMS_M_MEM_READ]);
    go(`CMS_C_LD_PAIR, n);
    t = {bus.mem(cap_a[`CMS_M_OPER_HIGH]), bus.mem(cap_a[`CMS_M_OPER_LOW])};
    `CHK("pair_states", 20, n);
    `CHK("pair_step", 3'h5, machine_step);
    `CHK("pair_high_op", cap_a[`CMS_M_OPER_LOW] + 16'h0001, cap_a[`CMS_M_OPER_HIGH]);
    `CHK("pair_low_rd", t, cap_a[`CMS_M_READ_LOW]);
    `CHK("pair_high_rd", t + 16'h0001, cap_a[`CMS_M_READ_HIGH]);
    `CHK("pair_word", {bus.mem(t + 16'h0001), bus.mem(t)}, read_word);
  endtask
  task automatic t_push;
    int n;
    go(`CMS_C_PUSH, n);
    `CHK("push_states", 11, n);
    `CHK("push_sp", sp0 - 16'h0002, stack_pointer);
    `CHK("push_hi_addr", sp0 - 16'h0001, cap_a[`CMS_M_STACK_HIGH]);
    `CHK("push_hi_data", 8'h12, cap_d[`CMS_M_STACK_HIGH]);
    `CHK("push_lo_addr", sp0 - 16'h0002, cap_a[`CMS_M_STACK_LOW]);
    `CHK("push_lo_data", 8'h34, cap_d[`CMS_M_STACK_LOW]);
  endtask
  task automatic t_copy;
    int n;
    int s;
    s = steps;
    go(`CMS_C_COPY, n);
    `CHK("copy_states", 16, n);
    `CHK("copy_pc", pc0 + 16'h0002, pc);
    `CHK("copy_step", s, steps);
    `CHK("copy_step_pulse", 1'b1, length_count_step);
    copy_last = 1'b0;
    go(`CMS_C_COPY_REP, n);
    `CHK("rep_states", 21, n);
    `CHK("rep_pc", pc0, pc);
    `CHK("rep_step", s + 2, steps);
    copy_last = 1'b1;
    go(`CMS_C_COPY_REP, n);
    `CHK("rep_last_states", 16, n);
  endtask
  task automatic t_irq;
    int n;
    go(`CMS_C_NMI, n);
    `CHK("nmi_states", 11, n);
    `CHK("nmi_pc", `CMS_NMI_ADDR, pc);
    `CHK("nmi_hi", pc0[15:8], cap_d[`CMS_M_STACK_HIGH]);
    `CHK("nmi_lo", pc0[7:0], cap_d[`CMS_M_STACK_LOW]);
    go(`CMS_C_INT0_RST, n);
    `CHK("rst_states", 12, n);
    `CHK("rst_pc", restart_target, pc);
    `CHK("rst_lo", pc0[7:0], cap_d[`CMS_M_STACK_LOW]);
    mode0_call = 1'b1;
    go(`CMS_C_INT0_RST, n);
    mode0_call = 1'b0;
    `CHK("call_states", 18, n);
    `CHK("call_pc", {bus.mem(pc0 + 16'h0001), bus.mem(pc0)}, pc);
    `CHK("call_hi", pc0[15:8], cap_d[`CMS_M_STACK_HIGH]);
    go(`CMS_C_INT2, n);
    t = {vector_base, ack_byte};
    `CHK("vec_states", 18, n);
    `CHK("vec_hi", pc0[15:8], cap_d[`CMS_M_STACK_HIGH]);
    `CHK("vec_pc", {bus.mem(t + 16'h0001), bus.mem(t)}, pc);
  endtask
  task automatic t_wait;
    int n;
    slow = 1'b1;
    go(`CMS_C_LD_IMM, n);
    slow = 1'b0;
    `CHK("wait_stretch", 1'b1, n > 7 && n < 13);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    t_loads;
    t_push;
    t_copy;
    t_irq;
    t_wait;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
